// File: qdl_regs.svh
// Register offsets, field positions and timing counts of the four-channel load control.
// Assumes a 32-bit Wishbone slave with one aligned word per register.
`ifndef QDL_REGS_SVH
`define QDL_REGS_SVH

// Register indices; the byte address is four times the index.
`define QDL_IDX_MODE 3'h0
`define QDL_IDX_DATA 3'h2
`define QDL_IDX_CTRL 3'h4
`define QDL_IDX_ISTS 3'h6
`define QDL_IDX_IMSK 3'h7

// Base address decode: the switch value compares with these address bits.
`define QDL_BASE_HI 14
`define QDL_BASE_LO 5
`define QDL_IDX_HI 4
`define QDL_IDX_LO 2

// Mode and identification register fields.
`define QDL_MODE_IDENT_LO 8
`define QDL_MODE_LED 6
`define QDL_MODE_CURRENT_RANGE_OFFSET_FLAG 3
// Identification code; the value is arbitrary.
`define QDL_IDENT_CODE 8'h5A

// Control and status register fields.
`define QDL_CTRL_AVAIL 15
`define QDL_CTRL_SEL_HI 9
`define QDL_CTRL_SEL_LO 8
`define QDL_CTRL_READY 7
`define QDL_CTRL_OPEN 5
`define QDL_CTRL_FNCT 4

// Interrupt status and mask bits.
`define QDL_INT_READY 0
`define QDL_INT_OPEN 1
`define QDL_INT_HOLD 2

// Timing.
`define QDL_CLK_MHZ 200
`define QDL_RDY_MIN_US 1
`define QDL_RDY_MAX_US 150
`define QDL_RDY_MIN_CYC (`QDL_RDY_MIN_US * `QDL_CLK_MHZ)
`define QDL_HOLD_MIN_US 150
`define QDL_STEP_LAST 2'h3
`define QDL_PEND_ROUNDS 3'h5

`endif

// File: qdl_pkg.sv
// Types of the four-channel converter load control.
// Assumes the constants of qdl_regs.svh.
package qdl_pkg;

    typedef enum logic [1:0] {
        QDL_PH_MSB,
        QDL_PH_LSB,
        QDL_PH_XFER
    } qdl_phase_t;

    typedef struct packed {
        logic [3:0][11:0] chan;
        logic [1:0] sel;
        logic led;
        logic fnct;
        logic [9:0] sw_s1;
        logic [9:0] sw_s2;
        logic [3:0] opl_s1;
        logic [3:0] opl_s2;
        logic [3:0] opl_prev;
        logic rng_s1;
        logic rng_s2;
        logic hold_s1;
        logic hold_s2;
        logic hold_prev;
        logic [1:0] ch;
        qdl_phase_t ph;
        logic [1:0] stp;
        logic [11:0] word;
        logic [7:0] dac_data;
        logic [3:0] cs;
        logic wr_msb;
        logic wr_lsb;
        logic [3:0] xfer;
        logic busy;
        logic [7:0] rdy_min;
        logic [2:0] pend;
        logic [2:0] ists;
        logic [2:0] imsk;
        logic ack;
        logic [31:0] dat;
    } qdl_state_t;

endpackage

// File: qdl_top.sv
// Load control of a four-channel 12-bit converter output module, with a Wishbone slave.
// Assumes a classic Wishbone master on core_clk_i and converter parts on the dac_ pins.
`timescale 1ns/1ps

module qdl_top
    import qdl_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic [9:0] base_switch_i,
    input wire logic current_range_offset_flag_i,
    input wire logic [3:0] open_circuit_flag_i,
    input wire logic latch_hold_input_i,
    output logic [7:0] dac_data_o,
    output logic [3:0] dac_cs_o,
    output logic dac_wr_msb_o,
    output logic dac_wr_lsb_o,
    output logic [3:0] dac_hold_load_o,
    output logic led_o,
    output logic fnct_o
);

`include "qdl_regs.svh"

    qdl_state_t s_q;
    qdl_state_t s_d;

    logic req;
    logic hit;
    logic [2:0] idx;
    logic wr_ok;
    logic rd_ok;
    logic hold_active;
    logic hold_rise;
    logic seq_adv;
    logic xfer_end;
    logic [3:0] opl_rise;
    logic [2:0] ev;
    logic [15:0] mode_ident_reg;
    logic [15:0] ctrl_stat;
    logic [11:0] cur_word;

    always_comb begin
        s_d = s_q;

        // Pin inputs pass two flip-flops before anything looks at them.
        s_d.sw_s1 = base_switch_i;
        s_d.sw_s2 = s_q.sw_s1;
        s_d.opl_s1 = open_circuit_flag_i;
        s_d.opl_s2 = s_q.opl_s1;
        s_d.opl_prev = s_q.opl_s2;
        s_d.rng_s1 = current_range_offset_flag_i;
        s_d.rng_s2 = s_q.rng_s1;
        s_d.hold_s1 = latch_hold_input_i;
        s_d.hold_s2 = s_q.hold_s1;
        s_d.hold_prev = s_q.hold_s2;

        // The latch-hold pin idles high when nobody drives it, so low means hold.
        hold_active = ~s_q.hold_s2;
        hold_rise = s_q.hold_s2 & ~s_q.hold_prev;
        opl_rise = s_q.opl_s2 & ~s_q.opl_prev;

        // Bus decode.
        idx = wb_adr_i[`QDL_IDX_HI:`QDL_IDX_LO];
        hit = (wb_adr_i[`QDL_BASE_HI:`QDL_BASE_LO] == s_q.sw_s2);
        req = wb_cyc_i & wb_stb_i & hit & ~s_q.ack;
        wr_ok = req & wb_we_i;
        rd_ok = req & ~wb_we_i;

        mode_ident_reg = 16'h0000;
        mode_ident_reg[15:`QDL_MODE_IDENT_LO] = `QDL_IDENT_CODE;
        mode_ident_reg[`QDL_MODE_LED] = s_q.led;
        mode_ident_reg[`QDL_MODE_CURRENT_RANGE_OFFSET_FLAG] = s_q.rng_s2;

        ctrl_stat = 16'h0000;
        ctrl_stat[`QDL_CTRL_AVAIL] = 1'b1;
        ctrl_stat[`QDL_CTRL_SEL_HI:`QDL_CTRL_SEL_LO] = s_q.sel;
        ctrl_stat[`QDL_CTRL_READY] = ~s_q.busy;
        ctrl_stat[`QDL_CTRL_OPEN] = s_q.opl_s2[s_q.sel];
        ctrl_stat[`QDL_CTRL_FNCT] = s_q.fnct;

        // Sequencer: each phase lasts four cycles so data settles around the strobe.
        s_d.stp = s_q.stp + 2'h1;
        seq_adv = (s_q.stp == `QDL_STEP_LAST);
        xfer_end = seq_adv & (s_q.ph == QDL_PH_XFER);
        cur_word = s_q.chan[s_q.ch + 2'h1];
        if (seq_adv) begin
            unique case (s_q.ph)
                QDL_PH_MSB: begin
                    s_d.ph = QDL_PH_LSB;
                end
                QDL_PH_LSB: begin
                    s_d.ph = QDL_PH_XFER;
                end
                QDL_PH_XFER: begin
                    s_d.ph = QDL_PH_MSB;
                    s_d.ch = s_q.ch + 2'h1;
                    s_d.word = cur_word;
                end
                default: begin
                    s_d.ph = QDL_PH_MSB;
                end
            endcase
        end

        // Converter outputs follow the next sequencer state so they come from flip-flops.
        if (s_d.ph == QDL_PH_MSB) begin
            s_d.dac_data = s_d.word[11:4];
        end else begin
            s_d.dac_data = {4'h0, s_d.word[3:0]};
        end
        if (s_d.ph == QDL_PH_XFER) begin
            s_d.cs = 4'h0;
        end else begin
            s_d.cs = 4'h1 << s_d.ch;
        end
        s_d.wr_msb = (s_d.ph == QDL_PH_MSB) & (s_d.stp[0] ^ s_d.stp[1]);
        s_d.wr_lsb = (s_d.ph == QDL_PH_LSB) & (s_d.stp[0] ^ s_d.stp[1]);
        s_d.xfer = 4'h0;
        if ((s_d.ph == QDL_PH_XFER) & (s_d.stp[0] ^ s_d.stp[1]) & ~hold_active) begin
            s_d.xfer = 4'h1 << s_d.ch;
        end
        if (hold_rise) begin
            s_d.xfer = 4'hF;
        end

        // Ready returns after a minimum time and once five transfer phases have passed, even while the latch-hold input blocks the loads.
        if (s_q.rdy_min != 8'h00) begin
            s_d.rdy_min = s_q.rdy_min - 8'h01;
        end
        if (xfer_end && s_q.pend != 3'h0) begin
            s_d.pend = s_q.pend - 3'h1;
        end
        if (s_q.busy && s_q.pend == 3'h0 && s_q.rdy_min == 8'h00) begin
            s_d.busy = 1'b0;
        end

        // Register writes.
        if (wr_ok) begin
            unique case (idx)
                `QDL_IDX_MODE: begin
                    if (wb_sel_i[0]) begin
                        s_d.led = wb_dat_i[`QDL_MODE_LED];
                    end
                end
                `QDL_IDX_DATA: begin
                    // A write while not ready or without both low byte lanes is dropped.
                    if (~s_q.busy && wb_sel_i[1:0] == 2'h3) begin
                        s_d.chan[s_q.sel] = wb_dat_i[11:0];
                        s_d.busy = 1'b1;
                        s_d.pend = `QDL_PEND_ROUNDS;
                        s_d.rdy_min = 8'(`QDL_RDY_MIN_CYC);
                    end
                end
                `QDL_IDX_CTRL: begin
                    if (wb_sel_i[1]) begin
                        s_d.sel = wb_dat_i[`QDL_CTRL_SEL_HI:`QDL_CTRL_SEL_LO];
                    end
                    if (wb_sel_i[0]) begin
                        s_d.fnct = wb_dat_i[`QDL_CTRL_FNCT];
                    end
                end
                `QDL_IDX_IMSK: begin
                    if (wb_sel_i[0]) begin
                        s_d.imsk = wb_dat_i[2:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Register reads; unmapped words in the block read as zero.
        s_d.ack = req;
        s_d.dat = 32'h0000_0000;
        if (rd_ok) begin
            unique case (idx)
                `QDL_IDX_MODE: begin
                    s_d.dat = {16'h0000, mode_ident_reg};
                end
                `QDL_IDX_CTRL: begin
                    s_d.dat = {16'h0000, ctrl_stat};
                end
                `QDL_IDX_ISTS: begin
                    s_d.dat = {29'h0000_0000, s_q.ists};
                    s_d.ists = 3'h0;
                end
                `QDL_IDX_IMSK: begin
                    s_d.dat = {29'h0000_0000, s_q.imsk};
                end
                default: begin
                end
            endcase
        end

        // Events are applied after the read clear so a coinciding event is kept.
        ev = 3'h0;
        ev[`QDL_INT_READY] = s_q.busy & ~s_d.busy;
        ev[`QDL_INT_OPEN] = |opl_rise;
        ev[`QDL_INT_HOLD] = hold_rise;
        s_d.ists = s_d.ists | ev;
    end

    // Reset leaves every field but the latch-hold stages zero: channels cleared, sequencer at channel 0, ready set.
    // The latch-hold stages start at the pin's idle high level, so release shows no false rise.
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.hold_s1 <= 1'b1;
            s_q.hold_s2 <= 1'b1;
            s_q.hold_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.dat;
    assign irq_o = |(s_q.ists & s_q.imsk);
    assign dac_data_o = s_q.dac_data;
    assign dac_cs_o = s_q.cs;
    assign dac_wr_msb_o = s_q.wr_msb;
    assign dac_wr_lsb_o = s_q.wr_lsb;
    assign dac_hold_load_o = s_q.xfer;
    assign led_o = s_q.led;
    assign fnct_o = s_q.fnct;

endmodule

// File: qdl_chk.sv
// Port assertions of the converter load control.
// Assumes one clock domain and a base switch that stays put.
`timescale 1ns/1ps
module qdl_chk (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [9:0] base_switch_i,
    input wire logic wb_ack_o,
    input wire logic latch_hold_input_i,
    input wire logic [7:0] dac_data_o,
    input wire logic [3:0] dac_cs_o,
    input wire logic dac_wr_msb_o,
    input wire logic dac_wr_lsb_o,
    input wire logic [3:0] dac_hold_load_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    a_ack_in_block: assert property (wb_ack_o |->
        $past(wb_cyc_i && wb_stb_i && wb_adr_i[14:5] == base_switch_i)) else $error("stray ack");
    a_wr_two_cycles: assert property ($rose(dac_wr_msb_o) |=>
        dac_wr_msb_o ##1 !dac_wr_msb_o) else $error("msb strobe length");
    a_msb_then_lsb: assert property ($rose(dac_wr_msb_o) |->
        ##4 (dac_wr_lsb_o && dac_cs_o == $past(dac_cs_o, 4))) else $error("lsb step missing");
    a_lsb_upper_zero: assert property (dac_wr_lsb_o |->
        dac_data_o[7:4] == 4'h0) else $error("lsb step data");
    a_cs_one_hot: assert property (dac_wr_msb_o || dac_wr_lsb_o |->
        $onehot(dac_cs_o)) else $error("select not one-hot");
    a_round_robin: assert property ($rose(dac_wr_msb_o) |->
        ##12 $rose(dac_wr_msb_o)) else $error("channel period");
    a_hold_blocks: assert property ((!latch_hold_input_i) [*5] |->
        dac_hold_load_o == 4'h0) else $error("transfer while held");
    a_hold_rise_all: assert property ($rose(latch_hold_input_i) |->
        ##[1:5] dac_hold_load_o == 4'hF) else $error("no common load");
endmodule
bind qdl_top qdl_chk qdl_chk_i (.core_clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_adr_i,
    .base_switch_i, .wb_ack_o, .latch_hold_input_i, .dac_data_o, .dac_cs_o,
    .dac_wr_msb_o, .dac_wr_lsb_o, .dac_hold_load_o);

// File: qdl_conv_model.sv
// Behavioural model of the four converter parts.
// Assumes strobes that stand at least one full cycle.
`timescale 1ns/1ps
module qdl_conv_model (
    input wire logic core_clk_i,
    input wire logic [7:0] dac_data_i,
    input wire logic [3:0] dac_cs_i,
    input wire logic dac_wr_msb_i,
    input wire logic dac_wr_lsb_i,
    input wire logic [3:0] dac_hold_load_i,
    output logic [3:0][11:0] held_o
);
    logic [3:0][11:0] latch_q = '0;
    initial held_o = '0;
    always @(posedge core_clk_i) begin
        for (int c = 0; c < 4; c++) begin
            if (dac_cs_i[c] && dac_wr_msb_i) latch_q[c][11:4] <= dac_data_i;
            if (dac_cs_i[c] && dac_wr_lsb_i) latch_q[c][3:0] <= dac_data_i[3:0];
            if (dac_hold_load_i[c]) held_o[c] <= latch_q[c];
        end
    end
endmodule

// File: quad_dac_load_control_bench.sv
// Self-checking bench of the converter load control with a Wishbone master.
// Assumes the converter model and the bound checker.
`timescale 1ns/1ps
`include "qdl_regs.svh"
module quad_dac_load_control_bench;
    logic clk = 0;
    logic rst = 1;
    logic cyc = 0, stb = 0, we = 0, hold = 1, rng = 0, ack, irq, wm, wl, led, fnct;
    logic [31:0] adr = '0, wdat = '0, rdat, r;
    logic [3:0] sel = '0, open_circuit_flag = '0, cs, hl;
    logic [9:0] sw = 10'h2A5;
    logic [7:0] dd;
    logic [3:0][11:0] held;
    integer fails = 0, n_tests = 0, seed = 15, c, k, cycles = 0, t0;
    int exp_w[4];
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) cycles <= cycles + 1;
    qdl_top qdl_top_i (.core_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_o(irq), .base_switch_i(sw), .current_range_offset_flag_i(rng),
        .open_circuit_flag_i(open_circuit_flag), .latch_hold_input_i(hold), .dac_data_o(dd),
        .dac_cs_o(cs), .dac_wr_msb_o(wm), .dac_wr_lsb_o(wl), .dac_hold_load_o(hl),
        .led_o(led), .fnct_o(fnct));
    qdl_conv_model qdl_conv_model_i (.core_clk_i(clk), .dac_data_i(dd), .dac_cs_i(cs),
        .dac_wr_msb_i(wm), .dac_wr_lsb_i(wl), .dac_hold_load_i(hl), .held_o(held));
    task automatic check(input logic [31:0] seen, want, input string what);
        n_tests++;
        if (seen !== want) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // One classic cycle; the request stands until the edge that samples ack.
    task automatic wb(input logic w, input logic [2:0] idx, input logic [31:0] d,
        input logic [3:0] s);
        int n = 0;
        cyc <= 1;
        stb <= 1;
        we <= w;
        sel <= s;
        wdat <= d;
        adr <= {17'h0, sw, idx, 2'h0};
        @(posedge clk);
        while (ack !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (ack !== 1'b1) begin
            fails++;
            wrap_up();
        end
        r = rdat;
        cyc <= 0;
        stb <= 0;
        @(posedge clk);
    endtask
    task automatic wait_ready;
        int n = 0;
        do begin
            wb(0, `QDL_IDX_CTRL, 0, 4'hF);
            n++;
        end while (r[`QDL_CTRL_READY] !== 1'b1 && n < 300);
        if (r[`QDL_CTRL_READY] !== 1'b1) begin
            fails++;
            wrap_up();
        end
    endtask
    initial begin
        @(posedge clk);
        rng <= 1'($random(seed));
        open_circuit_flag <= 4'($random(seed));
        repeat (7) @(posedge clk);
        rst <= 0;
        repeat (4) @(posedge clk);
        wb(0, `QDL_IDX_MODE, 0, 4'hF);
        check(r, {16'h0, `QDL_IDENT_CODE, 4'h0, rng, 3'h0}, "mode");
        wb(0, 3'h1, 0, 4'hF);
        check(r, 0, "unmapped");
        // A request outside the switch-selected block must never be answered.
        cyc <= 1;
        stb <= 1;
        we <= 0;
        adr <= {17'h0, ~sw, 5'h00};
        repeat (6) begin
            @(posedge clk);
            check(ack, 0, "foreign block");
        end
        cyc <= 0;
        stb <= 0;
        @(posedge clk);
        wb(1, `QDL_IDX_MODE, 32'h0000_0040, 4'h1);
        check(led, 1, "led pin");
        wb(1, `QDL_IDX_CTRL, 32'h0000_0010, 4'h1);
        check(fnct, 1, "fnct pin");
        for (c = 0; c < 4; c++) begin
            // Codes below 5 LSB would leave the open flag untrustworthy.
            exp_w[c] = 5 + {$random(seed)} % 4091;
            wb(1, `QDL_IDX_CTRL, c << 8, 4'h3);
            wb(1, `QDL_IDX_DATA, exp_w[c], 4'h3);
            t0 = cycles;
            // A second write while not ready must be dropped.
            wb(1, `QDL_IDX_DATA, exp_w[c] ^ 12'hFFF, 4'h3);
            wb(0, `QDL_IDX_CTRL, 0, 4'hF);
            check(r[`QDL_CTRL_READY], 0, "ready");
            check(r[`QDL_CTRL_OPEN], open_circuit_flag[c], "open flag");
            check(r[9:8], c[1:0], "select");
            wait_ready;
            check(cycles - t0 >= `QDL_RDY_MIN_CYC, 1, "ready time");
            repeat (96) @(posedge clk);
            check(held[c], exp_w[c], "held word");
        end
        for (c = 0; c < 4; c++) check(held[c], exp_w[c], "re-copy");
        check(irq, 0, "irq masked");
        wb(1, `QDL_IDX_IMSK, 1, 4'hF);
        check(irq, 1, "irq raised");
        wb(0, `QDL_IDX_ISTS, 0, 4'hF);
        check(r[`QDL_INT_READY], 1, "ready event");
        check(r[`QDL_INT_OPEN], open_circuit_flag != 0, "open event");
        check(r[`QDL_INT_HOLD], 0, "no false hold edge");
        check(irq, 0, "irq cleared");
        hold <= 0;
        k = 5 + {$random(seed)} % 4091;
        wb(1, `QDL_IDX_CTRL, 0, 4'h3);
        wb(1, `QDL_IDX_DATA, k, 4'h3);
        wait_ready;
        // The source keeps the low level for the minimum hold time.
        repeat (`QDL_HOLD_MIN_US * `QDL_CLK_MHZ) @(posedge clk);
        check(held[0], exp_w[0], "held while low");
        hold <= 1;
        exp_w[0] = k;
        repeat (8) @(posedge clk);
        for (c = 0; c < 4; c++) check(held[c], exp_w[c], "common load");
        wb(0, `QDL_IDX_ISTS, 0, 4'hF);
        check(r[`QDL_INT_HOLD], 1, "hold event");
        rst <= 1;
        @(posedge clk);
        rst <= 0;
        repeat (100) @(posedge clk);
        for (c = 0; c < 4; c++) check(held[c], 0, "after reset");
        wb(0, `QDL_IDX_CTRL, 0, 4'hF);
        check(r[`QDL_CTRL_READY], 1, "ready after reset");
        wrap_up();
    end
endmodule
